// >>> hdl/oivs_sense_ctrl.sv
/*
 * Status and control logic around the identification line detectors and
 * the bus supply comparators: status flags, edge latches, power-down wake,
 * ground switch with self-clearing pulse requests, supply-valid debounce
 * and charge pump mode, reached over an Avalon-MM slave with waitrequest.
 * Assumes detector and comparator outputs are synchronous to clk_i.
 */
// Operation
// - software reaches identification, control and latch registers through the register slave
// - charge pump runs in drive, SRP pull-up or discharge pull-down mode
// - supply-valid debounce timer runs only while pump drive is on
// - supply below the valid threshold counts as a fault for A-devices
// - session-valid and a separate session-end indication are reported
// - five identification conditions each have their own status bit
// - in power-down only open-line detector stays on and can wake chip
// - enabled edge of open-line or session flag sets its latch bit, raising interrupt
// - force bit turns ground switch on; no bits set keeps it off
// - pulse request alone gives one timed pulse, then request clears itself
// - delayed request alone waits, gives one timed pulse, then clears itself
module oivs_sense_ctrl #(
	parameter int PULSE_TIME_US = oivs_pkg::PULSE_TIME_US,
	parameter int WAIT_TIME_US = oivs_pkg::WAIT_TIME_US,
	parameter int DEBOUNCE_TIME_US = oivs_pkg::DEBOUNCE_TIME_US
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire oivs_pkg::oivs_sense_t sense_i,
	output oivs_pkg::oivs_pump_mode_t pump_mode_o,
	output logic pump_drive_on_o,
	output logic ident_ground_switch_o,
	output logic [4:0] detect_enable_o,
	output logic vbus_fault_o,
	output logic wake_o,
	output logic irq_o
);

	// cycle counts derived from the times
	localparam int PULSE_CYCLES = PULSE_TIME_US * oivs_pkg::CLK_MHZ;
	localparam int WAIT_CYCLES = WAIT_TIME_US * oivs_pkg::CLK_MHZ;
	localparam int DEB_CYCLES = DEBOUNCE_TIME_US * oivs_pkg::CLK_MHZ;

	// counters are 32 bits wide; a zero count cannot be served
	if (PULSE_CYCLES < 1 || WAIT_CYCLES < 1 || DEB_CYCLES < 1)
	begin : g_bad_time
		$error("oivs_sense_ctrl: every time must give at least one cycle");
	end

	logic [1:0] ctl_pump;
	logic ctl_force, ctl_pulse, ctl_delayed, ctl_pdown;
	logic [3:0] edge_en, latch, edge_event;
	oivs_pkg::oivs_sense_t sense_q, sense_prev;
	logic vbus_valid_deb, pulse_from_delayed, pulse_done, pump_on;
	logic [31:0] deb_cnt, pulse_cnt, next_readdata;
	oivs_pkg::oivs_pulse_state_t pulse_state;
	logic wr_ctl, wr_latch, wr_edge, bus_take;

	// a request completes at the edge where waitrequest is seen low
	assign bus_take = (avs_read_i || avs_write_i) && !avs_waitrequest_o;
	assign wr_ctl = bus_take && avs_write_i && avs_byteenable_i[0]
		&& avs_address_i == oivs_pkg::ADDR_CONTROL;
	assign wr_edge = bus_take && avs_write_i && avs_byteenable_i[0]
		&& avs_address_i == oivs_pkg::ADDR_EDGE_EN;
	assign wr_latch = bus_take && avs_write_i && avs_byteenable_i[0]
		&& avs_address_i == oivs_pkg::ADDR_LATCH;
	assign pump_on = ctl_pump == oivs_pkg::OIVS_PUMP_DRIVE;
	assign pulse_done = pulse_state == oivs_pkg::OIVS_ST_PULSE && pulse_cnt == 32'h00000000;

	// one wait cycle per access: data is ready when waitrequest falls
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			avs_waitrequest_o <= 1'b1;
		else if ((avs_read_i || avs_write_i) && avs_waitrequest_o)
			avs_waitrequest_o <= 1'b0;
		else
			avs_waitrequest_o <= 1'b1;
	end

	// read mux; unmapped addresses read as zero
	always_comb
	begin
		next_readdata = 32'h00000000;
		unique case (avs_address_i)
			oivs_pkg::ADDR_STATUS:
			begin
				next_readdata[7:0] = sense_q;
				next_readdata[oivs_pkg::STS_VBUS_DEB] = vbus_valid_deb;
				next_readdata[oivs_pkg::STS_FAULT] = vbus_fault_o;
				next_readdata[oivs_pkg::STS_SWITCH] = ident_ground_switch_o;
				next_readdata[oivs_pkg::STS_PDOWN] = ctl_pdown;
			end
			oivs_pkg::ADDR_CONTROL:
				next_readdata[5:0] = {ctl_pdown, ctl_delayed, ctl_pulse, ctl_force, ctl_pump};
			oivs_pkg::ADDR_EDGE_EN: next_readdata[3:0] = edge_en;
			oivs_pkg::ADDR_LATCH: next_readdata[3:0] = latch;
			default: next_readdata = 32'h00000000;
		endcase
	end

	// read data is captured while waitrequest is still high
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			avs_readdata_o <= 32'h00000000;
		else if (avs_read_i && avs_waitrequest_o)
			avs_readdata_o <= next_readdata;
	end

	// pump mode, force and power-down bits; power-down is left by a wake
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			ctl_pump <= oivs_pkg::CTL_RESET[1:0];
			ctl_force <= oivs_pkg::CTL_RESET[oivs_pkg::CTL_FORCE];
			ctl_pdown <= oivs_pkg::CTL_RESET[oivs_pkg::CTL_PDOWN];
		end
		else
		begin
			if (wr_ctl)
			begin
				ctl_pump <= avs_writedata_i[oivs_pkg::CTL_PUMP_LSB +: 2];
				ctl_force <= avs_writedata_i[oivs_pkg::CTL_FORCE];
				ctl_pdown <= avs_writedata_i[oivs_pkg::CTL_PDOWN];
			end
			// the wake wins over a write in the same cycle
			if (ctl_pdown && sense_q.open_line != sense_prev.open_line)
				ctl_pdown <= 1'b0;
		end
	end

	// pulse request bits: a software write beats the self-clear
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			ctl_pulse <= oivs_pkg::CTL_RESET[oivs_pkg::CTL_PULSE];
			ctl_delayed <= oivs_pkg::CTL_RESET[oivs_pkg::CTL_DELAYED];
		end
		else if (wr_ctl)
		begin
			ctl_pulse <= avs_writedata_i[oivs_pkg::CTL_PULSE];
			ctl_delayed <= avs_writedata_i[oivs_pkg::CTL_DELAYED];
		end
		else if (pulse_done && pulse_from_delayed)
			ctl_delayed <= 1'b0;
		else if (pulse_done)
			ctl_pulse <= 1'b0;
	end

	// ground switch pulse sequencer; both requests set together is left idle
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			pulse_state <= oivs_pkg::OIVS_ST_IDLE;
			pulse_cnt <= 32'h00000000;
			pulse_from_delayed <= 1'b0;
		end
		else
		begin
			unique case (pulse_state)
				oivs_pkg::OIVS_ST_IDLE:
					if (!ctl_force && ctl_pulse && !ctl_delayed)
					begin
						pulse_state <= oivs_pkg::OIVS_ST_PULSE;
						pulse_cnt <= 32'(PULSE_CYCLES - 1);
						pulse_from_delayed <= 1'b0;
					end
					else if (!ctl_force && ctl_delayed && !ctl_pulse)
					begin
						pulse_state <= oivs_pkg::OIVS_ST_WAIT;
						pulse_cnt <= 32'(WAIT_CYCLES - 1);
						pulse_from_delayed <= 1'b1;
					end
				oivs_pkg::OIVS_ST_WAIT:
					if (pulse_cnt == 32'h00000000)
					begin
						pulse_state <= oivs_pkg::OIVS_ST_PULSE;
						pulse_cnt <= 32'(PULSE_CYCLES - 1);
					end
					else
						pulse_cnt <= pulse_cnt - 32'h00000001;
				oivs_pkg::OIVS_ST_PULSE:
					if (pulse_cnt == 32'h00000000)
						pulse_state <= oivs_pkg::OIVS_ST_IDLE;
					else
						pulse_cnt <= pulse_cnt - 32'h00000001;
				default:
					pulse_state <= oivs_pkg::OIVS_ST_IDLE;
			endcase
		end
	end

	// force overrides the sequencer; otherwise only a pulse closes the switch
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			ident_ground_switch_o <= 1'b0;
		else
			ident_ground_switch_o <= ctl_force || pulse_state == oivs_pkg::OIVS_ST_PULSE;
	end

	// sensed flags; detectors switched off in power-down read as zero
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			sense_q <= '0;
			sense_prev <= '0;
		end
		else
		begin
			sense_q <= sense_i;
			if (ctl_pdown)
			begin
				sense_q.short_gnd <= 1'b0;
				sense_q.r_low <= 1'b0;
				sense_q.r_mid <= 1'b0;
				sense_q.r_high <= 1'b0;
			end
			sense_prev <= sense_q;
		end
	end

	// detector enables and wake pulse on an open-line change
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			detect_enable_o <= oivs_pkg::DET_ALL_ON;
			wake_o <= 1'b0;
		end
		else
		begin
			detect_enable_o <= ctl_pdown ? oivs_pkg::DET_PDOWN : oivs_pkg::DET_ALL_ON;
			wake_o <= ctl_pdown && sense_q.open_line != sense_prev.open_line;
		end
	end

	// supply-valid debounce, bypassed while the pump is not driving
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			deb_cnt <= 32'h00000000;
			vbus_valid_deb <= 1'b0;
		end
		else if (!pump_on)
		begin
			deb_cnt <= 32'h00000000;
			vbus_valid_deb <= sense_q.vbus_valid;
		end
		else if (!sense_q.vbus_valid)
		begin
			deb_cnt <= 32'h00000000;
			vbus_valid_deb <= 1'b0;
		end
		else if (deb_cnt == 32'(DEB_CYCLES - 1))
			vbus_valid_deb <= 1'b1;
		else
			deb_cnt <= deb_cnt + 32'h00000001;
	end

	// pump outputs and fault; fault is only meaningful while driving
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			pump_mode_o <= oivs_pkg::OIVS_PUMP_OFF;
			pump_drive_on_o <= 1'b0;
			vbus_fault_o <= 1'b0;
		end
		else
		begin
			pump_mode_o <= oivs_pkg::oivs_pump_mode_t'(ctl_pump);
			pump_drive_on_o <= pump_on;
			vbus_fault_o <= pump_on && !vbus_valid_deb;
		end
	end

	// edge enables
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			edge_en <= oivs_pkg::EDGE_RESET;
		else if (wr_edge)
			edge_en <= avs_writedata_i[3:0];
	end

	assign edge_event[oivs_pkg::EDGE_OPEN_RISE] = sense_q.open_line && !sense_prev.open_line;
	assign edge_event[oivs_pkg::EDGE_OPEN_FALL] = !sense_q.open_line && sense_prev.open_line;
	assign edge_event[oivs_pkg::EDGE_SESS_RISE] =
		sense_q.session_valid && !sense_prev.session_valid;
	assign edge_event[oivs_pkg::EDGE_SESS_FALL] =
		!sense_q.session_valid && sense_prev.session_valid;

	// sticky latch, write one to clear; a new edge wins over the clear
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			latch <= 4'h0;
		else
			latch <= (latch & ~(wr_latch ? avs_writedata_i[3:0] : 4'h0))
				| (edge_event & edge_en);
	end

	// interrupt request follows the latch one cycle later
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			irq_o <= 1'b0;
		else
			irq_o <= |latch;
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);
	sequence s_bus_req;
		(avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence
	sequence s_pulse_start;
		$rose(pulse_state == oivs_pkg::OIVS_ST_PULSE);
	endsequence

	bus_answer_a: assert property (s_bus_req |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
		else $error("bus request not answered after one wait cycle");
	pump_mode_a: assert property (pump_drive_on_o == (pump_mode_o == oivs_pkg::OIVS_PUMP_DRIVE))
		else $error("pump drive flag disagrees with pump mode");
	debounce_off_a: assert property (!pump_on |=> deb_cnt == 32'h00000000)
		else $error("debounce timer running while pump is off");
	fault_flag_a: assert property (pump_on && !vbus_valid_deb |=> vbus_fault_o)
		else $error("supply fault not flagged");
	pdown_mask_a: assert property (ctl_pdown |=> detect_enable_o == oivs_pkg::DET_PDOWN
		&& !sense_q.short_gnd)
		else $error("detectors not switched off in power-down");
	latch_set_a: assert property (|(edge_event & edge_en) |=> (latch & $past(edge_event & edge_en))
		== $past(edge_event & edge_en) ##1 irq_o)
		else $error("enabled edge did not latch and interrupt");
	force_on_a: assert property (ctl_force |=> ident_ground_switch_o)
		else $error("ground switch off while forced");
	switch_off_a: assert property (!ctl_force && pulse_state == oivs_pkg::OIVS_ST_IDLE
		|=> !ident_ground_switch_o)
		else $error("ground switch on with no request");
	pulse_length_a: assert property (s_pulse_start |-> pulse_cnt == 32'(PULSE_CYCLES - 1))
		else $error("pulse started with wrong length");
	pulse_clear_a: assert property (pulse_done && !pulse_from_delayed && !wr_ctl |=> !ctl_pulse
		##1 !ident_ground_switch_o || $past(ctl_force))
		else $error("pulse request did not clear itself");
	delayed_wait_a: assert property (pulse_state == oivs_pkg::OIVS_ST_WAIT
		&& pulse_cnt == 32'h00000000 |=> pulse_state == oivs_pkg::OIVS_ST_PULSE)
		else $error("delayed pulse did not follow the wait");
	delayed_clear_a: assert property (pulse_done && pulse_from_delayed && !wr_ctl
		|=> !ctl_delayed)
		else $error("delayed request did not clear itself");

endmodule

// >>> hdl/oivs_pkg.sv
/*
 * Shared constants and types of the identification line and bus supply
 * sense logic: register offsets, field positions, reset values, timing
 * defaults and the carrier of the detector and comparator outputs.
 * Assumes a single 25 MHz clock and a 32-bit memory-mapped register bus.
 */
package oivs_pkg;

	// clock rate in MHz, used to turn microseconds into cycles
	localparam int CLK_MHZ = 25;

	// timing defaults in microseconds, figures of our own since none are fixed
	localparam int PULSE_TIME_US = 100;
	localparam int WAIT_TIME_US = 1000;
	localparam int DEBOUNCE_TIME_US = 1000;

	// register byte offsets
	localparam logic [3:0] ADDR_STATUS = 4'h0;
	localparam logic [3:0] ADDR_CONTROL = 4'h4;
	localparam logic [3:0] ADDR_EDGE_EN = 4'h8;
	localparam logic [3:0] ADDR_LATCH = 4'hC;

	// control register fields
	localparam int CTL_PUMP_LSB = 0;
	localparam int CTL_FORCE = 2;
	localparam int CTL_PULSE = 3;
	localparam int CTL_DELAYED = 4;
	localparam int CTL_PDOWN = 5;
	localparam logic [5:0] CTL_RESET = 6'h00;

	// edge enable and latch fields
	localparam int EDGE_OPEN_RISE = 0;
	localparam int EDGE_OPEN_FALL = 1;
	localparam int EDGE_SESS_RISE = 2;
	localparam int EDGE_SESS_FALL = 3;
	localparam logic [3:0] EDGE_RESET = 4'h0;

	// status register fields above the eight sense bits
	localparam int STS_VBUS_DEB = 8;
	localparam int STS_FAULT = 9;
	localparam int STS_SWITCH = 10;
	localparam int STS_PDOWN = 11;

	// detector enables: bit 0 is the open-line detector
	localparam logic [4:0] DET_ALL_ON = 5'h1F;
	localparam logic [4:0] DET_PDOWN = 5'h01;

	typedef enum logic [1:0] {
		OIVS_PUMP_OFF = 2'b00,
		OIVS_PUMP_DRIVE = 2'b01,
		OIVS_PUMP_SRP_PULLUP = 2'b10,
		OIVS_PUMP_DISCHARGE = 2'b11
	} oivs_pump_mode_t;

	typedef enum logic [1:0] {
		OIVS_ST_IDLE = 2'b00,
		OIVS_ST_WAIT = 2'b01,
		OIVS_ST_PULSE = 2'b10
	} oivs_pulse_state_t;

	// detector and comparator outputs, one bit each
	typedef struct packed {
		logic open_line;
		logic short_gnd;
		logic r_low;
		logic r_mid;
		logic r_high;
		logic vbus_valid;
		logic session_valid;
		logic session_end;
	} oivs_sense_t;

endpackage

// >>> tb/oivs_ctrl_model.sv
/*
 * Behavioural model of the controller that reaches the sense block:
 * an Avalon-MM master with single-word accesses and an accessory decode.
 * Assumes one clock shared with the block and a slave with waitrequest.
 */
module oivs_ctrl_model (
	input wire logic clk_i,
	input wire logic [31:0] avs_readdata_i,
	input wire logic avs_waitrequest_i,
	output logic [3:0] avs_address_o,
	output logic avs_read_o,
	output logic avs_write_o,
	output logic [3:0] avs_byteenable_o,
	output logic [31:0] avs_writedata_o,
	output logic hang_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// idle bus at time zero
	initial
	begin
		avs_address_o = 4'h0;
		avs_read_o = 1'b0;
		avs_write_o = 1'b0;
		avs_byteenable_o = 4'hF;
		avs_writedata_o = 32'h0;
		hang_o = 1'b0;
	end

	// one access, raised after an edge and held until waitrequest is seen low
	task automatic access(input logic wr, input logic [3:0] addr, input logic [31:0] wdata,
		input logic [3:0] lanes, output logic [31:0] rdata);
		int n = 0;
		@(posedge clk_i);
		avs_address_o <= addr;
		avs_read_o <= !wr;
		avs_write_o <= wr;
		avs_writedata_o <= wdata;
		avs_byteenable_o <= lanes;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (avs_waitrequest_i !== 1'b0 && n < 50);
		rdata = avs_readdata_i;
		hang_o <= hang_o | (avs_waitrequest_i !== 1'b0);
		avs_read_o <= 1'b0;
		avs_write_o <= 1'b0;
		// stale data would hide a slave that samples after release
		avs_writedata_o <= ~wdata;
	endtask

	// accessory class: 0 none, 1 A-device, 2 phone, 3 charger 1, 4 charger 2, 5 carkit or PC
	function automatic logic [2:0] classify(input logic [7:0] s);
		casez ({s[1], s[7:3]})
			6'b0_100??: return 3'h0;
			6'b0_01000: return 3'h1;
			6'b0_00100: return 3'h2;
			6'b1_00010: return 3'h3;
			6'b1_00001: return 3'h4;
			6'b1_10000: return 3'h5;
			default: return 3'h7;
		endcase
	endfunction
endmodule

// >>> tb/oivs_sense_ctrl_test.sv
/*
 * Self-checking bench for the sense and control block: table of sense
 * and pump settings, then reset, debounce, edge latch, power-down and
 * ground switch cases. Assumes a 25 MHz clock and short timer parameters.
 */
module oivs_sense_ctrl_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int PC = 25;
	localparam int WC = 50;
	localparam int DC = 25;
	typedef struct packed {
		logic [5:0] ctl;
		logic [7:0] sense;
		logic [1:0] mode;
		logic drive;
	} oivs_row_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	oivs_pkg::oivs_sense_t sense = '0;
	logic [3:0] addr;
	logic rd_en;
	logic wr_en;
	logic [3:0] be;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic wreq;
	oivs_pkg::oivs_pump_mode_t pmode;
	logic drv;
	logic sw;
	logic [4:0] det;
	logic fault;
	logic wake;
	logic irq;
	logic hang;
	int fail_count = 0;
	int cmp_count = 0;
	logic [31:0] rd;
	int lead;
	int width;
	int n;
	logic [3:0] addrs [5] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h2};
	oivs_row_t rows [8] = '{{6'h00, 8'h80, 2'h0, 1'b0}, {6'h00, 8'h40, 2'h0, 1'b0},
		{6'h00, 8'h20, 2'h0, 1'b0}, {6'h00, 8'h10, 2'h0, 1'b0}, {6'h00, 8'h08, 2'h0, 1'b0},
		{6'h01, 8'h06, 2'h1, 1'b1}, {6'h02, 8'h01, 2'h2, 1'b0}, {6'h03, 8'h00, 2'h3, 1'b0}};

	always #20 clk = ~clk;

	// short timers keep every case within a few hundred cycles
	oivs_sense_ctrl #(
		.PULSE_TIME_US(1),
		.WAIT_TIME_US(2),
		.DEBOUNCE_TIME_US(1)
	) dut_u (.clk_i(clk), .reset_i(rst), .avs_address_i(addr), .avs_read_i(rd_en),
		.avs_write_i(wr_en), .avs_byteenable_i(be), .avs_writedata_i(wdata),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .sense_i(sense),
		.pump_mode_o(pmode), .pump_drive_on_o(drv), .ident_ground_switch_o(sw),
		.detect_enable_o(det), .vbus_fault_o(fault), .wake_o(wake), .irq_o(irq));

	oivs_ctrl_model ctl_u (.clk_i(clk), .avs_readdata_i(rdata), .avs_waitrequest_i(wreq),
		.avs_address_o(addr), .avs_read_o(rd_en), .avs_write_o(wr_en),
		.avs_byteenable_o(be), .avs_writedata_o(wdata), .hang_o(hang));

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] x;
		ctl_u.access(1'b1, a, d, 4'hF, x);
	endtask

	task automatic rdreg(input logic [3:0] a);
		ctl_u.access(1'b0, a, 32'h0, 4'hF, rd);
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask

	task automatic sense_set(input logic [7:0] v);
		@(posedge clk);
		sense <= v;
	endtask

	// cycles before the switch closes and cycles it stays closed
	task automatic measure();
		lead = 0;
		width = 0;
		repeat (200)
		begin
			@(posedge clk);
			if (sw === 1'b1)
				width++;
			else if (width == 0)
				lead++;
		end
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// a bus access that never completes ends the run
	always @(posedge hang)
	begin
		fail_count++;
		report_and_stop();
	end

	initial
	begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		// table of identification conditions and pump modes
		foreach (rows[i])
		begin
			sense_set(rows[i].sense);
			wr(oivs_pkg::ADDR_CONTROL, {26'h0, rows[i].ctl});
			cyc(2);
			rdreg(oivs_pkg::ADDR_STATUS);
			check("status", rd[7:0], rows[i].sense);
			check("pump_mode", pmode, rows[i].mode);
			check("drive_on", drv, rows[i].drive);
		end
		// reset state of outputs and registers, unmapped place included
		sense_set(8'h00);
		rst <= 1'b1;
		cyc(3);
		check("waitrequest", wreq, 1'b1);
		check("detect_en", det, oivs_pkg::DET_ALL_ON);
		check("switch", sw, 1'b0);
		@(posedge clk);
		rst <= 1'b0;
		wr(4'h2, 32'hFF);
		// lane 0 off: the control write must be ignored
		ctl_u.access(1'b1, oivs_pkg::ADDR_CONTROL, 32'h3F, 4'hE, rd);
		foreach (addrs[i])
		begin
			rdreg(addrs[i]);
			check("reset_reg", rd, 32'h0);
		end
		// debounce follows the comparator while the pump is off
		sense_set(8'h04);
		cyc(3);
		rdreg(oivs_pkg::ADDR_STATUS);
		check("deb_off", rd[oivs_pkg::STS_VBUS_DEB], 1'b1);
		sense_set(8'h00);
		wr(oivs_pkg::ADDR_CONTROL, 32'h1);
		sense_set(8'h04);
		cyc(5);
		rdreg(oivs_pkg::ADDR_STATUS);
		check("deb_early", rd[oivs_pkg::STS_VBUS_DEB], 1'b0);
		cyc(DC);
		rdreg(oivs_pkg::ADDR_STATUS);
		check("deb_late", rd[oivs_pkg::STS_VBUS_DEB], 1'b1);
		check("no_fault", fault, 1'b0);
		sense_set(8'h00);
		cyc(4);
		check("fault", fault, 1'b1);
		// edge latches and interrupt, with the session fall left disabled
		wr(oivs_pkg::ADDR_CONTROL, 32'h0);
		wr(oivs_pkg::ADDR_LATCH, 32'hF);
		wr(oivs_pkg::ADDR_EDGE_EN, 32'h7);
		sense_set(8'h80);
		cyc(4);
		check("irq_set", irq, 1'b1);
		rdreg(oivs_pkg::ADDR_LATCH);
		check("latch_open", rd, 32'h1);
		wr(oivs_pkg::ADDR_LATCH, 32'h1);
		cyc(2);
		check("irq_clr", irq, 1'b0);
		sense_set(8'h12);
		cyc(4);
		rdreg(oivs_pkg::ADDR_LATCH);
		check("latch_two", rd, 32'h6);
		rdreg(oivs_pkg::ADDR_STATUS);
		check("class", ctl_u.classify(rd[7:0]), 3'h3);
		wr(oivs_pkg::ADDR_LATCH, 32'hF);
		sense_set(8'h10);
		cyc(4);
		rdreg(oivs_pkg::ADDR_LATCH);
		check("latch_off", rd, 32'h0);
		// power-down masks all but the open-line detector, which wakes
		sense_set(8'h40);
		wr(oivs_pkg::ADDR_CONTROL, 32'h20);
		cyc(3);
		check("detect_pd", det, oivs_pkg::DET_PDOWN);
		rdreg(oivs_pkg::ADDR_STATUS);
		check("status_pd", rd[7:0], 8'h00);
		sense_set(8'hC0);
		n = 0;
		repeat (10)
		begin
			@(posedge clk);
			n += int'(wake === 1'b1);
		end
		check("wake", n, 1);
		rdreg(oivs_pkg::ADDR_CONTROL);
		check("pd_clear", rd[oivs_pkg::CTL_PDOWN], 1'b0);
		// force, single pulse and delayed pulse on the ground switch
		wr(oivs_pkg::ADDR_CONTROL, 32'h4);
		cyc(3);
		check("force_on", sw, 1'b1);
		wr(oivs_pkg::ADDR_CONTROL, 32'h0);
		cyc(3);
		check("force_off", sw, 1'b0);
		wr(oivs_pkg::ADDR_CONTROL, 32'h8);
		measure();
		check("pulse_len", width, PC);
		rdreg(oivs_pkg::ADDR_CONTROL);
		check("pulse_clr", rd[4:3], 2'h0);
		wr(oivs_pkg::ADDR_CONTROL, 32'h10);
		measure();
		check("dly_len", width, PC);
		check("dly_wait", lead >= WC, 1'b1);
		rdreg(oivs_pkg::ADDR_CONTROL);
		check("dly_clr", rd[4:3], 2'h0);
		// both requests together: switch stays open, bits are left alone
		wr(oivs_pkg::ADDR_CONTROL, 32'h18);
		measure();
		check("both_off", width, 0);
		rdreg(oivs_pkg::ADDR_CONTROL);
		check("both_keep", rd[4:3], 2'h3);
		report_and_stop();
	end
endmodule
